// >>> pir_top.sv
// interrupt request flags, enables and vector entry for six peripheral sources
// assumes event pulses on clk_i, an asynchronous comparator level, a wishbone master
//
// The address map and register access over Wishbone were decided locally.
`timescale 1ns/10ps
module pir_top
   import pir_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [PIR_ADR_W-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // peripheral events, one-cycle pulses on clk_i; the comparator output is an asynchronous level
   input wire logic basic_timer_ovf_i,
   input wire logic counter_a_ovf_i,
   input wire logic counter_b_ovf_i,
   input wire logic wide_timer_ovf_i,
   input wire logic serial_done_i,
   input wire logic comparator_out_i,
   // core sequencer
   input wire logic core_ready_i,
   input wire logic core_reti_i,
   output logic vector_load_o,
   output logic [11:0] vector_addr_o,
   output logic stack_push_o,
   output logic comparator_enable_o
);

   // ****************************************
   // register state
   // ****************************************
   logic [7:0] request_flag_register_q;
   logic [7:0] request_flag_register_d;
   logic [7:0] irq_enable_q;
   logic global_irq_enable_q;
   logic comparator_enable_q;
   logic [1:0] comparator_edge_select_q;
   logic ack_q;
   logic [31:0] rdata_q;
   pir_state_t state_q;
   logic vector_load_q;
   logic stack_push_q;
   logic [11:0] vector_addr_q;
   logic pending_q;

   // ****************************************
   // bus decode
   // ****************************************
   logic [7:0] reg_idx;
   logic bus_req;
   logic wr_lo;
   logic wr_flags;
   logic wr_enable;
   logic wr_global;
   logic wr_cmp;

   assign reg_idx = adr_i[PIR_ADR_W-1:2];
   assign bus_req = cyc_i & stb_i;
   // writes land on the edge where ack is seen high by the master
   assign wr_lo = bus_req & we_i & ack_q & sel_i[0];
   assign wr_flags = wr_lo & (reg_idx == PIR_IDX_FLAGS);
   assign wr_enable = wr_lo & (reg_idx == PIR_IDX_ENABLE);
   assign wr_global = wr_lo & (reg_idx == PIR_IDX_GLOBAL);
   assign wr_cmp = wr_lo & (reg_idx == PIR_IDX_CMP_CTRL);

   // one wait state; ack falls the cycle after it is given
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= bus_req & ~ack_q;
      end
   end

   // unmapped indices answer with zero data
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_q <= 32'h0000_0000;
      end else if (bus_req & ~ack_q) begin
         case (reg_idx)
            PIR_IDX_FLAGS: begin
               rdata_q <= {24'h00_0000, request_flag_register_q};
            end
            PIR_IDX_ENABLE: begin
               rdata_q <= {24'h00_0000, irq_enable_q};
            end
            PIR_IDX_GLOBAL: begin
               rdata_q <= {24'h00_0000, global_irq_enable_q, 7'h00};
            end
            PIR_IDX_CMP_CTRL: begin
               rdata_q <= {29'h0000_0000, comparator_edge_select_q, comparator_enable_q};
            end
            PIR_IDX_STATUS: begin
               rdata_q <= {30'h0000_0000, pending_q, state_q == PIR_ST_SERVE};
            end
            default: begin
               rdata_q <= 32'h0000_0000;
            end
         endcase
      end
   end

   // ****************************************
   // control registers
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_enable_q <= PIR_RST_ENABLE;
      end else if (wr_enable) begin
         irq_enable_q <= dat_i[7:0] & PIR_IMPL_MASK;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         global_irq_enable_q <= PIR_RST_GIE;
      end else if (wr_global) begin
         global_irq_enable_q <= dat_i[PIR_BIT_GIE];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         comparator_enable_q <= PIR_RST_CMP_EN;
         comparator_edge_select_q <= PIR_RST_EDGE_SEL;
      end else if (wr_cmp) begin
         comparator_enable_q <= dat_i[PIR_BIT_CMP_EN];
         comparator_edge_select_q <= dat_i[PIR_POS_EDGE_SEL +: 2];
      end
   end

   // ****************************************
   // comparator edge detection
   // ****************************************
   // the analog output is asynchronous: two flops, then a third for the edge
   logic cmp_meta_q;
   logic cmp_sync_q;
   logic cmp_prev_q;
   logic cmp_rise;
   logic cmp_fall;
   logic cmp_event;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cmp_meta_q <= 1'b0;
         cmp_sync_q <= 1'b0;
         cmp_prev_q <= 1'b0;
      end else begin
         cmp_meta_q <= comparator_out_i;
         cmp_sync_q <= cmp_meta_q;
         cmp_prev_q <= cmp_sync_q;
      end
   end

   assign cmp_rise = cmp_sync_q & ~cmp_prev_q;
   assign cmp_fall = ~cmp_sync_q & cmp_prev_q;

   always_comb begin
      case (comparator_edge_select_q)
         PIR_EDGE_RISE: cmp_event = cmp_rise;
         PIR_EDGE_FALL: cmp_event = cmp_fall;
         PIR_EDGE_BOTH: cmp_event = cmp_rise | cmp_fall;
         default: cmp_event = 1'b0;
      endcase
   end

   // ****************************************
   // request flags
   // ****************************************
   logic [7:0] event_vec;

   always_comb begin
      event_vec = 8'h00;
      event_vec[PIR_BIT_BASIC] = basic_timer_ovf_i;
      event_vec[PIR_BIT_CNT_A] = counter_a_ovf_i;
      event_vec[PIR_BIT_CNT_B] = counter_b_ovf_i;
      event_vec[PIR_BIT_WIDE] = wide_timer_ovf_i;
      event_vec[PIR_BIT_SERIAL] = serial_done_i;
      // a stopped comparator can raise nothing
      event_vec[PIR_BIT_CMP] = cmp_event & comparator_enable_q;
   end

   // flags are only ever cleared by software writes; the event wins a tie
   // so that an overflow landing on the clear edge is never lost
   for (genvar b = 0; b < 8; b++) begin : g_flag
      if (PIR_IMPL_MASK[b]) begin : g_impl
         always_comb begin
            if (event_vec[b]) begin
               request_flag_register_d[b] = 1'b1;
            end else if (wr_flags) begin
               request_flag_register_d[b] = dat_i[b];
            end else begin
               request_flag_register_d[b] = request_flag_register_q[b];
            end
         end

         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               request_flag_register_q[b] <= PIR_RST_FLAGS[b];
            end else begin
               request_flag_register_q[b] <= request_flag_register_d[b];
            end
         end
      end else begin : g_hole
         // unimplemented position always reads zero
         always_comb begin
            request_flag_register_d[b] = 1'b0;
         end

         always_ff @(posedge clk_i) begin
            request_flag_register_q[b] <= 1'b0;
         end
      end
   end

   // ****************************************
   // vector entry
   // ****************************************
   // enable bits gate only delivery, never the flags themselves
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pending_q <= 1'b0;
      end else begin
         pending_q <= global_irq_enable_q & (|(request_flag_register_q & irq_enable_q));
      end
   end

   // one entry per service; the core signals return to re-arm
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= PIR_ST_IDLE;
         vector_load_q <= 1'b0;
         stack_push_q <= 1'b0;
      end else begin
         vector_load_q <= 1'b0;
         stack_push_q <= 1'b0;
         case (state_q)
            PIR_ST_IDLE: begin
               if (pending_q & core_ready_i & global_irq_enable_q) begin
                  vector_load_q <= 1'b1;
                  stack_push_q <= 1'b1;
                  state_q <= PIR_ST_SERVE;
               end
            end
            PIR_ST_SERVE: begin
               if (core_reti_i) begin
                  state_q <= PIR_ST_IDLE;
               end
            end
            default: begin
               state_q <= PIR_ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         vector_addr_q <= PIR_VECTOR_ADDR;
      end else begin
         vector_addr_q <= PIR_VECTOR_ADDR;
      end
   end

   assign dat_o = rdata_q;
   assign ack_o = ack_q;
   assign vector_load_o = vector_load_q;
   assign stack_push_o = stack_push_q;
   assign vector_addr_o = vector_addr_q;
   assign comparator_enable_o = comparator_enable_q;

endmodule

// >>> pir_pkg.sv
// constants for the peripheral interrupt request block
// assumes a 32-bit classic wishbone bus with 8-bit registers in the low byte
package pir_pkg;

   // ****************************************
   // register indices, byte address is index * 4
   // ****************************************
   localparam logic [7:0] PIR_IDX_FLAGS = 8'hc8;
   localparam logic [7:0] PIR_IDX_ENABLE = 8'hc9;
   localparam logic [7:0] PIR_IDX_GLOBAL = 8'hdf;
   localparam logic [7:0] PIR_IDX_CMP_CTRL = 8'he0;
   localparam logic [7:0] PIR_IDX_STATUS = 8'he1;
   localparam int PIR_ADR_W = 10;

   // ****************************************
   // bit positions in the flag and enable registers
   // ****************************************
   localparam int PIR_BIT_PIN = 0;
   localparam int PIR_BIT_WIDE = 2;
   localparam int PIR_BIT_SERIAL = 3;
   localparam int PIR_BIT_BASIC = 4;
   localparam int PIR_BIT_CNT_A = 5;
   localparam int PIR_BIT_CNT_B = 6;
   localparam int PIR_BIT_CMP = 7;
   localparam logic [7:0] PIR_IMPL_MASK = 8'hfd;

   // global enable, comparator control and status fields
   localparam int PIR_BIT_GIE = 7;
   localparam int PIR_BIT_CMP_EN = 0;
   localparam int PIR_POS_EDGE_SEL = 1;
   localparam int PIR_POS_IN_SERVICE = 0;
   localparam int PIR_POS_PENDING = 1;

   // ****************************************
   // reset values and vector
   // ****************************************
   localparam logic [7:0] PIR_RST_FLAGS = 8'h00;
   localparam logic [7:0] PIR_RST_ENABLE = 8'h00;
   localparam logic PIR_RST_GIE = 1'b0;
   localparam logic PIR_RST_CMP_EN = 1'b0;
   localparam logic [1:0] PIR_RST_EDGE_SEL = 2'h1;
   localparam logic [11:0] PIR_VECTOR_ADDR = 12'h008;

   // comparator edge selection codes
   localparam logic [1:0] PIR_EDGE_NONE = 2'h0;
   localparam logic [1:0] PIR_EDGE_RISE = 2'h1;
   localparam logic [1:0] PIR_EDGE_FALL = 2'h2;
   localparam logic [1:0] PIR_EDGE_BOTH = 2'h3;

   typedef enum logic {
      PIR_ST_IDLE = 1'b0,
      PIR_ST_SERVE = 1'b1
   } pir_state_t;

endpackage

// >>> pir_core_model.sv
// core sequencer stand-in: takes vector entries, returns after a while
// assumes the block's registered entry pulses on clk_i
`timescale 1ns/10ps
module pir_core_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic slow_i,
   input wire logic vector_load_i,
   input wire logic stack_push_i,
   output logic core_ready_o,
   output logic core_reti_o,
   output int entries_o
);
   logic [2:0] busy_q;
   logic tick_q;
   always_ff @(posedge clk_i) begin
      tick_q <= rst_i ? 1'b0 : !tick_q;
   end
   // a slow core accepts entry only every other cycle
   assign core_ready_o = !slow_i || tick_q;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         busy_q <= 3'h0;
         entries_o <= 0;
      end else if (vector_load_i && stack_push_i) begin
         busy_q <= 3'h4;
         entries_o <= entries_o + 1;
      end else if (busy_q != 3'h0) begin
         busy_q <= busy_q - 3'h1;
      end
   end
   assign core_reti_o = busy_q == 3'h1;
endmodule

// >>> pir_top_asserts.sv
// port checker for the request block
// assumes pir_top, one clock, synchronous reset
`timescale 1ns/10ps
module pir_top_chk
   import pir_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire logic core_ready_i,
   input wire logic core_reti_i,
   input wire logic vector_load_o,
   input wire logic [11:0] vector_addr_o,
   input wire logic stack_push_o,
   input wire logic comparator_enable_o
);
   logic srv_q;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   sequence wb_req_s;
      cyc_i && stb_i && !ack_o;
   endsequence
   sequence entry_s;
      vector_load_o && stack_push_o;
   endsequence
   // in service from entry until the core returns
   always_ff @(posedge clk_i) begin
      if (rst_i) srv_q <= 1'b0;
      else if (vector_load_o) srv_q <= 1'b1;
      else if (core_reti_i) srv_q <= 1'b0;
   end
   // ****
   // properties
   // ****
   ack_delay_a: assert property (wb_req_s |=> ack_o) else $error("ack missing");
   ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack held");
   rd_upper_a: assert property (ack_o |-> dat_o[31:8] == 24'h0) else $error("upper bits");
   vec_addr_a: assert property (vector_addr_o == PIR_VECTOR_ADDR) else $error("vector");
   push_pair_a: assert property (vector_load_o == stack_push_o) else $error("push");
   entry_gap_a: assert property (entry_s |=> !vector_load_o [*2]) else $error("gap");
   entry_ready_a: assert property (entry_s |-> $past(core_ready_i)) else $error("ready");
   one_entry_a: assert property (srv_q |-> !vector_load_o) else $error("nested entry");
   rst_quiet_a: assert property (disable iff (1'b0)
      rst_i |=> !ack_o && !vector_load_o && !comparator_enable_o) else $error("reset");
endmodule
bind pir_top pir_top_chk chk_u (.clk_i, .rst_i, .cyc_i, .stb_i, .dat_o, .ack_o, .core_ready_i,
   .core_reti_i, .vector_load_o, .vector_addr_o, .stack_push_o, .comparator_enable_o);

// >>> peripheral_interrupt_requests_tb.sv
// self-checking bench for the request block
// assumes the core stand-in and the bound checker
`timescale 1ns/10ps
module peripheral_interrupt_requests_tb
   import pir_pkg::*;
   ;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic we_i = 1'b0;
   logic [9:0] adr_i = 10'h0;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0;
   logic [4:0] ovf_q = 5'h0;
   logic cmp_q = 1'b0;
   logic slow_q = 1'b0;
   logic [31:0] dat_o;
   logic [11:0] vector_addr_o;
   logic ack_o, vector_load_o, stack_push_o, comparator_enable_o, ready, reti;
   int entries;
   int err_count = 0;
   int num_checks = 0;
   logic [31:0] seed = 32'he952cf22;
   int bitpos [5] = '{4, 5, 6, 2, 3};
   logic [7:0] rsel [6] = '{PIR_IDX_FLAGS, PIR_IDX_ENABLE, PIR_IDX_GLOBAL, PIR_IDX_CMP_CTRL,
      PIR_IDX_STATUS, 8'h10};
   logic [7:0] rexp [6] = '{8'h0, 8'h0, 8'h0, {5'h0, PIR_RST_EDGE_SEL, PIR_RST_CMP_EN}, 8'h0, 8'h0};
   always #10 clk_i = ~clk_i;
   pir_core_model core_u (.clk_i, .rst_i, .slow_i(slow_q), .vector_load_i(vector_load_o),
      .stack_push_i(stack_push_o), .core_ready_o(ready), .core_reti_o(reti), .entries_o(entries));
   pir_top dut_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
      .basic_timer_ovf_i(ovf_q[0]), .counter_a_ovf_i(ovf_q[1]), .counter_b_ovf_i(ovf_q[2]),
      .wide_timer_ovf_i(ovf_q[3]), .serial_done_i(ovf_q[4]), .comparator_out_i(cmp_q),
      .core_ready_i(ready), .core_reti_i(reti), .vector_load_o, .vector_addr_o, .stack_push_o,
      .comparator_enable_o);
   function automatic logic [7:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction
   function automatic logic want_cmp(logic [1:0] c, logic en, logic rise);
      return en && (rise ? c[0] : c[1]);
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      num_checks++;
      if (seen !== want) begin
         err_count++;
         $display("[ERR] %0t seen %h want %h", $time, seen, want);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic wb(input logic w, input logic [3:0] s, input logic [7:0] idx,
         input logic [7:0] d, output logic [31:0] q);
      int n;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      sel_i <= s;
      adr_i <= {idx, 2'b00};
      dat_i <= {24'h0, d};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      if (n >= 50) check(ack_o, 1'b1);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask
   // sources 0..4 pulse a timer or serial event, 5 and 6 move the comparator
   task automatic fire(input int s);
      @(posedge clk_i);
      if (s < 5) ovf_q[s] <= 1'b1;
      else cmp_q <= (s == 5);
      @(posedge clk_i);
      ovf_q <= 5'h0;
   endtask
   // wait covers sync, pending and a slow core
   task automatic judge(input int b, input logic f, input logic ent, input int e0);
      logic [31:0] q;
      repeat (10) @(posedge clk_i);
      wb(1'b0, 4'h1, PIR_IDX_FLAGS, 8'h0, q);
      check(q[b], f);
      check(entries != e0, ent);
      wb(1'b0, 4'h1, PIR_IDX_STATUS, 8'h0, q);
      check(q[PIR_POS_PENDING], ent);
      wb(1'b1, 4'h1, PIR_IDX_FLAGS, 8'h0, q);
      repeat (12) @(posedge clk_i);
   endtask
   initial begin
      #400000;
      err_count++;
      wrap_up();
   end
   initial begin
      logic [31:0] q;
      logic [7:0] r;
      logic w;
      int e0;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         wb(1'b0, 4'h1, rsel[i], 8'h0, q);
         check(q, {24'h0, rexp[i]});
      end
      for (int i = 0; i < 4; i++) begin
         r = xs();
         wb(1'b1, 4'h1, PIR_IDX_FLAGS, r, q);
         wb(1'b0, 4'h1, PIR_IDX_FLAGS, 8'h0, q);
         check(q, {24'h0, r & PIR_IMPL_MASK});
      end
      wb(1'b1, 4'h2, PIR_IDX_ENABLE, 8'hff, q);
      wb(1'b1, 4'h1, 8'h10, 8'hff, q);
      wb(1'b0, 4'h1, PIR_IDX_ENABLE, 8'h0, q);
      check(q, 32'h0);
      wb(1'b1, 4'h1, PIR_IDX_FLAGS, 8'h0, q);
      $display("registers done");
      for (int k = 0; k < 20; k++) begin
         r = xs();
         slow_q <= r[0];
         wb(1'b1, 4'h1, PIR_IDX_GLOBAL, {k >= 10, 7'h0}, q);
         wb(1'b1, 4'h1, PIR_IDX_ENABLE, 8'((k / 5 % 2) << bitpos[k % 5]), q);
         e0 = entries;
         fire(k % 5);
         judge(bitpos[k % 5], 1'b1, k >= 10 && k / 5 % 2 == 1, e0);
      end
      $display("sources done");
      wb(1'b1, 4'h1, PIR_IDX_ENABLE, 8'h80, q);
      for (int k = 0; k < 8; k++) begin
         wb(1'b1, 4'h1, PIR_IDX_CMP_CTRL, 8'(k), q);
         repeat (2) @(posedge clk_i);
         check(comparator_enable_o, k % 2);
         for (int d = 0; d < 2; d++) begin
            r = xs();
            slow_q <= r[0];
            e0 = entries;
            fire(5 + d);
            w = want_cmp(2'(k >> 1), k[0], d == 0);
            judge(7, w, w, e0);
         end
      end
      $display("comparator done");
      wb(1'b1, 4'h1, PIR_IDX_GLOBAL, 8'h0, q);
      fork
         wb(1'b1, 4'h1, PIR_IDX_FLAGS, 8'h0, q);
         begin
            repeat (2) @(posedge clk_i);
            ovf_q[0] <= 1'b1;
            @(posedge clk_i);
            ovf_q[0] <= 1'b0;
         end
      join
      wb(1'b0, 4'h1, PIR_IDX_FLAGS, 8'h0, q);
      check(q[PIR_BIT_BASIC], 1'b1);
      $display("collision done");
      wrap_up();
   end
endmodule
